//--- logic/emf_mac.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - fields go out preamble first, every octet lsb first
// - each frame starts with seven preamble octets
// - start delimiter 1010.1011 follows the preamble directly
// - lsb of first destination octet marks group address
// - length/type at most 1500 is a length, above that a type
// - length/type high byte is sent first
// - pad payload up to 46 octets only when padding enabled
// - no too-long error; overflow when frame misses the ram or 31 frames are already queued
// - crc-32 over addresses, length/type and data with pad, per nibble
// - append computed check, or send software check bytes when off
// - bad check frames dropped with error event when rejection on
// - duplex bit selects full duplex, clear means half duplex
// - transmit fifo holds one frame, 14 header bytes then payload
// - receive fifo queues up to 31 frames, overflow on no room
// - tx word one holds payload length, rx word one frame length
// - fifo word layout: length, addresses, length/type, then data
// - each received frame starts on a word boundary
// - nothing is sent until transmit enable is set
// - flush bit empties receive fifo
// - normal mode accepts only station address matches
// - maskable events for rx, collision, tx, overrun, error
module emf_mac
  import emf_pkg::*;
#(
  parameter int AW = 9
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // mii towards the phy
  input  wire logic        mii_tx_clk,
  output logic [3:0]       mii_txd,
  output logic             mii_tx_en,
  input  wire logic        mii_rx_clk,
  input  wire logic [3:0]  mii_rxd,
  input  wire logic        mii_rx_dv,
  input  wire logic        mii_crs,
  input  wire logic        mii_col
);
  localparam int KW = AW + 3;
  localparam logic [KW-1:0] HDR  = KW'(HDR_BYTES);
  localparam logic [KW-1:0] MINP = KW'(MIN_PAY);
  localparam logic [KW-1:0] HOFS = KW'(HDR_OFS);
  localparam logic [AW:0]   DEPTH = (AW+1)'(1 << AW);

  logic [8:0]     pin_s1_reg, pin_s2_reg;
  logic           txc_d_reg, rxc_d_reg;
  logic           awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]     bresp_reg, rresp_reg;
  logic [31:0]    rdata_reg, wdata_reg, sa_lo_reg, rd_val;
  logic [7:0]     awaddr_reg;
  logic [3:0]     wstrb_reg, tx_ctl_reg, rx_ctl_reg;
  logic [15:0]    sa_hi_reg;
  logic [5:0]     ev_reg, mask_reg, ev_set;
  logic           rd_hit;
  logic [31:0]    tx_mem [0:(1<<AW)-1];
  logic [31:0]    rx_mem [0:(1<<AW)-1];
  emf_tx_t        tx_st;
  logic [4:0]     tx_cnt;
  logic [KW-2:0]  tx_bp;
  logic [KW-1:0]  tx_sent;
  logic [AW:0]    tx_wr;
  logic           tx_nib, tx_go_reg, tx_err_f, transmit_on_reg;
  logic [3:0]     txd_reg;
  logic [31:0]    tx_crc, rx_crc;
  emf_rx_t        rx_st;
  logic [KW-1:0]  rx_k;
  logic           rx_nib, rx_da_ok, rx_grp, rx_ovf_f, last_type_reg;
  logic [3:0]     rx_lo;
  logic [15:0]    rx_lt;
  logic [AW-1:0]  rx_start, rx_rd;
  logic [AW:0]    rx_used, rx_left;
  logic [5:0]     rx_count;

  // pin synchronisers; only stage two feeds logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_reg <= 9'h000;
      pin_s2_reg <= 9'h000;
      txc_d_reg  <= 1'b0;
      rxc_d_reg  <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_crs, mii_col, mii_rxd};
      pin_s2_reg <= pin_s1_reg;
      txc_d_reg  <= pin_s2_reg[8];
      rxc_d_reg  <= pin_s2_reg[7];
    end
  end

  // tx drives on rising edge, rx samples on falling edge for margin
  wire       tx_tick = pin_s2_reg[8] & ~txc_d_reg;
  wire       rx_tick = ~pin_s2_reg[7] & rxc_d_reg;
  wire       dv_s    = pin_s2_reg[6];
  wire       crs_s   = pin_s2_reg[5];
  wire       col_s   = pin_s2_reg[4];
  wire [3:0] rxd_s   = pin_s2_reg[3:0];

  // bus handshakes and decode
  wire wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  wire rd_fire = s_axi_arvalid && arready_reg;
  wire w_ev    = wr_fire && awaddr_reg == A_EVENT;
  wire w_txc   = wr_fire && awaddr_reg == A_TXCTL && wstrb_reg[0];
  wire w_rxc   = wr_fire && awaddr_reg == A_RXCTL && wstrb_reg[0];
  wire w_salo  = wr_fire && awaddr_reg == A_SALO;
  wire w_sahi  = wr_fire && awaddr_reg == A_SAHI;
  wire w_data  = wr_fire && awaddr_reg == A_DATA;
  wire w_go    = wr_fire && awaddr_reg == A_TXGO && wdata_reg[0];
  wire w_mask  = wr_fire && awaddr_reg == A_MASK;
  wire wr_hit  = awaddr_reg <= A_MASK && awaddr_reg[1:0] == 2'b00 && awaddr_reg != A_MEV;
  wire rx_flush = w_rxc && wdata_reg[RC_FLS];
  wire rx_pop  = rd_fire && s_axi_araddr == A_DATA && rx_count != 6'h00;
  wire [31:0] sahi_mrg = bmerge({16'h0000, sa_hi_reg}, wdata_reg, wstrb_reg);

  // write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OK;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        awaddr_reg  <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      else if (wr_fire)
        awready_reg <= 1'b1;
      if (s_axi_wvalid && wready_reg)
      begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      else if (wr_fire)
        wready_reg <= 1'b1;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // read decode
  always_comb
  begin
    rd_hit = 1'b1;
    if (s_axi_araddr == A_EVENT) rd_val = {26'h0, ev_reg};
    else if (s_axi_araddr == A_TXCTL) rd_val = {28'h0, tx_ctl_reg};
    else if (s_axi_araddr == A_RXCTL) rd_val = {28'h0, rx_ctl_reg};
    else if (s_axi_araddr == A_SALO) rd_val = sa_lo_reg;
    else if (s_axi_araddr == A_SAHI) rd_val = {16'h0, sa_hi_reg};
    else if (s_axi_araddr == A_DATA) rd_val = rx_pop ? rx_mem[rx_rd] : 32'h0000_0000;
    else if (s_axi_araddr == A_TXGO) rd_val = {31'h0, tx_go_reg};
    else if (s_axi_araddr == A_MASK) rd_val = {26'h0, mask_reg};
    else if (s_axi_araddr == A_MEV) rd_val = {26'h0, ev_reg & mask_reg};
    else if (s_axi_araddr == A_RXCNT) rd_val = {25'h0, last_type_reg, rx_count};
    else
    begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b0;
    end
  end

  // read channel, data captured when the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OK;
    end
    else if (rd_fire)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_val;
      rresp_reg   <= rd_hit ? RESP_OK : RESP_ERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // control registers; events are write-one-to-clear, a set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_ctl_reg <= TXCTL_RST;
      rx_ctl_reg <= RXCTL_RST;
      sa_lo_reg  <= 32'h0000_0000;
      sa_hi_reg  <= 16'h0000;
      mask_reg   <= 6'h00;
      ev_reg     <= 6'h00;
    end
    else
    begin
      if (w_txc) tx_ctl_reg <= wdata_reg[3:0];
      if (w_rxc) rx_ctl_reg <= wdata_reg[3:0];
      if (w_salo) sa_lo_reg <= bmerge(sa_lo_reg, wdata_reg, wstrb_reg);
      if (w_sahi) sa_hi_reg <= sahi_mrg[15:0];
      if (w_mask) mask_reg <= wdata_reg[5:0];
      ev_reg <= (ev_reg & ~(w_ev ? wdata_reg[5:0] : 6'h00)) | ev_set;
    end
  end

  // ---- transmit ----
  wire [15:0]   tx_len   = tx_mem[0][15:0];
  wire [31:0]   tx_word  = tx_mem[tx_bp[KW-2:2]];
  wire [7:0]    tx_byte  = tx_word[{tx_bp[1:0], 3'b000} +: 8];
  wire [3:0]    tx_dnib  = tx_nib ? tx_byte[7:4] : tx_byte[3:0];
  wire [KW-1:0] tx_bend  = HDR + tx_len[KW-1:0];
  wire          tx_act   = tx_st != T_IDLE && tx_st != T_GAP;
  wire          tx_coll  = tx_tick && tx_act && !tx_ctl_reg[TC_DPX] && col_s;
  wire          tx_push  = w_data && !tx_go_reg && !tx_wr[AW];
  wire          tx_ok    = tx_tick && tx_st == T_GAP && tx_cnt == IFG_LAST && !tx_err_f;

  // software fills one frame; cleared when the frame is done
  always_ff @(posedge aclk)
  begin
    if (tx_push)
      tx_mem[tx_wr[AW-1:0]] <= wdata_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st <= T_IDLE;
      tx_cnt <= 5'h00;
      tx_bp <= '0;
      tx_sent <= '0;
      tx_wr <= '0;
      tx_nib <= 1'b0;
      tx_go_reg <= 1'b0;
      tx_err_f <= 1'b0;
      tx_crc <= CRC_INIT;
      transmit_on_reg <= 1'b0;
      txd_reg <= 4'h0;
    end
    else
    begin
      if (tx_push) tx_wr <= tx_wr + 1'b1;
      if (w_go && !tx_go_reg) tx_go_reg <= 1'b1;
      if (tx_coll)
      begin
        tx_st <= T_GAP; // half duplex collision abandons the frame
        tx_cnt <= 5'h00;
        tx_err_f <= 1'b1;
        transmit_on_reg <= 1'b0;
      end
      else if (tx_tick)
      begin
        case (tx_st)
          T_IDLE:
          begin
            transmit_on_reg <= 1'b0;
            txd_reg <= 4'h0;
            // waits for enable, and in half duplex for a quiet line
            if (tx_go_reg && tx_ctl_reg[TC_ON] && (tx_ctl_reg[TC_DPX] || !crs_s))
            begin
              tx_st <= T_PRE;
              tx_cnt <= 5'h00;
              tx_err_f <= 1'b0;
            end
          end
          T_PRE:
          begin
            transmit_on_reg <= 1'b1;
            txd_reg <= (tx_cnt == PRE_LAST) ? NIB_SFD : NIB_PRE;
            tx_cnt <= tx_cnt + 5'h01;
            if (tx_cnt == PRE_LAST)
            begin
              tx_st <= T_BODY;
              tx_bp <= HOFS[KW-2:0];
              tx_sent <= '0;
              tx_nib <= 1'b0;
              tx_crc <= CRC_INIT;
            end
          end
          T_BODY:
          begin
            txd_reg <= tx_dnib;
            tx_crc <= crc_nib(tx_crc, tx_dnib);
            tx_nib <= ~tx_nib;
            if (tx_nib)
            begin
              tx_bp <= tx_bp + 1'b1;
              tx_sent <= tx_sent + 1'b1;
              tx_cnt <= 5'h00;
              if (tx_sent + 1'b1 == tx_bend)
                tx_st <= (tx_ctl_reg[TC_PAD] && tx_len[KW-1:0] < MINP) ? T_PAD : T_FCS;
            end
          end
          T_PAD:
          begin
            txd_reg <= 4'h0;
            tx_crc <= crc_nib(tx_crc, 4'h0);
            tx_nib <= ~tx_nib;
            if (tx_nib)
            begin
              tx_sent <= tx_sent + 1'b1;
              if (tx_sent + 1'b1 == HDR + MINP) tx_st <= T_FCS;
            end
          end
          T_FCS:
          begin
            if (tx_ctl_reg[TC_CRC])
            begin
              txd_reg <= ~tx_crc[3:0];
              tx_crc <= tx_crc >> 4;
            end
            else
            begin
              txd_reg <= tx_dnib;
              tx_nib <= ~tx_nib;
              if (tx_nib) tx_bp <= tx_bp + 1'b1;
            end
            tx_cnt <= tx_cnt + 5'h01;
            if (tx_cnt == FCS_LAST)
            begin
              tx_st <= T_GAP;
              tx_cnt <= 5'h00;
            end
          end
          default:
          begin
            transmit_on_reg <= 1'b0;
            txd_reg <= 4'h0;
            tx_cnt <= tx_cnt + 5'h01;
            if (tx_cnt == IFG_LAST)
            begin
              tx_st <= T_IDLE;
              tx_go_reg <= 1'b0;
              tx_wr <= '0;
            end
          end
        endcase
      end
    end
  end

  a_pre_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_tick && !tx_coll && tx_st == T_PRE && tx_cnt != PRE_LAST |=> mii_txd == NIB_PRE && mii_tx_en)
    else $error("preamble nibble wrong");
  a_sfd_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_tick && !tx_coll && tx_st == T_PRE && tx_cnt == PRE_LAST |=> mii_txd == NIB_SFD ##1 tx_st == T_BODY)
    else $error("delimiter nibble wrong");
  a_tx_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st == T_IDLE && !tx_ctl_reg[TC_ON] |=> tx_st == T_IDLE && !mii_tx_en)
    else $error("sent while transmit disabled");
  a_half_defer: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st == T_IDLE && !tx_ctl_reg[TC_DPX] && crs_s |=> tx_st == T_IDLE)
    else $error("half duplex did not defer");
  a_pad_only: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st == T_PAD |-> tx_ctl_reg[TC_PAD] && tx_sent < HDR + MINP)
    else $error("pad outside its bounds");

  // ---- receive ----
  wire [KW-1:0] rx_p     = rx_k + HOFS;
  wire [AW:0]   rx_free  = DEPTH - rx_used;
  wire          ovf_now  = rx_p[KW-1:2] >= rx_free;
  wire [7:0]    rx_byte  = {rxd_s, rx_lo};
  wire [47:0]   sa48     = {sa_hi_reg, sa_lo_reg};
  wire          rx_bstep = rx_tick && rx_st == R_DATA && dv_s && rx_nib;
  wire          rx_bwr   = rx_bstep && !rx_ovf_f && !ovf_now;
  wire          rx_end   = rx_tick && rx_st == R_DATA && !dv_s;
  wire          rx_bad   = rx_crc != CRC_RES;
  wire          rx_acc   = rx_da_ok || rx_ctl_reg[RC_ALL]
                           || (rx_grp && rx_ctl_reg[RC_GRP]);
  wire          rx_keep  = rx_end && !rx_flush && rx_acc && !rx_ovf_f && rx_k != '0
                           && !(rx_bad && rx_ctl_reg[RC_BAD]);
  wire [15:0]   rx_fw16  = fw_of(16'(rx_k));
  wire [15:0]   rd_fw16  = fw_of(rx_mem[rx_rd][15:0]);
  wire [AW:0]   rx_fw    = rx_fw16[AW:0];
  wire [AW:0]   rd_fw    = rd_fw16[AW:0];
  wire          rx_done  = rx_pop && (rx_left == '0 ? rd_fw == 1 : rx_left == 1);
  wire [AW-1:0] rx_widx  = rx_start + rx_p[AW+1:2];

  assign ev_set = {1'b0, rx_end && rx_bad && !rx_ovf_f, rx_end && rx_ovf_f, tx_ok,
                   tx_coll, rx_keep && rx_count == 6'h00};

  // bytes land behind the length slot; length written on commit
  always_ff @(posedge aclk)
  begin
    if (rx_bwr)
      rx_mem[rx_widx][{rx_p[1:0], 3'b000} +: 8] <= rx_byte;
    else if (rx_keep)
      rx_mem[rx_start][15:0] <= 16'(rx_k);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st <= R_IDLE;
      rx_k <= '0;
      rx_nib <= 1'b0;
      rx_lo <= 4'h0;
      rx_crc <= CRC_INIT;
      rx_da_ok <= 1'b0;
      rx_grp <= 1'b0;
      rx_ovf_f <= 1'b0;
      rx_lt <= 16'h0000;
    end
    else if (rx_tick)
    begin
      case (rx_st)
        R_IDLE:
          if (dv_s) rx_st <= R_PRE;
        R_PRE:
          if (!dv_s) rx_st <= R_IDLE;
          else if (rxd_s == NIB_SFD)
          begin
            rx_st <= rx_ctl_reg[RC_ON] ? R_DATA : R_SKIP;
            rx_k <= '0;
            rx_nib <= 1'b0;
            rx_crc <= CRC_INIT;
            rx_da_ok <= 1'b1;
            rx_ovf_f <= rx_count >= MAX_FRMS;
          end
        R_DATA:
          if (!dv_s) rx_st <= R_IDLE;
          else
          begin
            rx_crc <= crc_nib(rx_crc, rxd_s);
            rx_nib <= ~rx_nib;
            if (!rx_nib) rx_lo <= rxd_s;
            else
            begin
              rx_k <= rx_k + 1'b1;
              if (ovf_now) rx_ovf_f <= 1'b1;
              if (rx_k < KW'(6) && rx_byte != sa48[{rx_k[2:0], 3'b000} +: 8])
                rx_da_ok <= 1'b0;
              if (rx_k == '0) rx_grp <= rx_byte[0];
              if (rx_k == KW'(12)) rx_lt[15:8] <= rx_byte;
              if (rx_k == KW'(13)) rx_lt[7:0] <= rx_byte;
            end
          end
        default:
          if (!dv_s) rx_st <= R_IDLE;
      endcase
    end
  end

  // queue bookkeeping; flush empties it outright
  always_ff @(posedge aclk)
  begin
    if (!aresetn || rx_flush)
    begin
      rx_start <= '0;
      rx_rd <= '0;
      rx_used <= '0;
      rx_left <= '0;
      rx_count <= 6'h00;
      if (!aresetn) last_type_reg <= 1'b0;
    end
    else
    begin
      rx_start <= rx_keep ? rx_start + rx_fw[AW-1:0] : rx_start;
      rx_used <= rx_used + (rx_keep ? rx_fw : '0) - {{AW{1'b0}}, rx_pop};
      rx_count <= rx_count + {5'h00, rx_keep} - {5'h00, rx_done};
      if (rx_keep) last_type_reg <= rx_lt > LEN_MAX;
      if (rx_pop)
      begin
        rx_rd <= rx_rd + 1'b1;
        rx_left <= (rx_left == '0) ? rd_fw - 1'b1 : rx_left - 1'b1;
      end
    end
  end

  a_keep_fits: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_keep |-> !rx_ovf_f && rx_count < MAX_FRMS)
    else $error("stored frame that overflowed");
  a_bad_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_end && rx_bad && rx_ctl_reg[RC_BAD] |-> !rx_keep ##1 ev_reg[4] || rx_ovf_f)
    else $error("bad frame kept or not flagged");
  a_filter_ok: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_keep |-> rx_da_ok || rx_ctl_reg[RC_ALL] || (rx_grp && rx_ctl_reg[RC_GRP]))
    else $error("frame passed the filter wrongly");
  a_flush_empty: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_flush |=> rx_count == 6'h00 && rx_used == '0)
    else $error("flush left data");

  // outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign mii_txd       = txd_reg;
  assign mii_tx_en     = transmit_on_reg;
endmodule

//--- logic/emf_pkg.sv
package emf_pkg;
  // register byte offsets
  localparam logic [7:0] A_EVENT = 8'h00;
  localparam logic [7:0] A_TXCTL = 8'h04;
  localparam logic [7:0] A_RXCTL = 8'h08;
  localparam logic [7:0] A_SALO  = 8'h0c;
  localparam logic [7:0] A_SAHI  = 8'h10;
  localparam logic [7:0] A_DATA  = 8'h14;
  localparam logic [7:0] A_TXGO  = 8'h18;
  localparam logic [7:0] A_MASK  = 8'h1c;
  localparam logic [7:0] A_MEV   = 8'h20;
  localparam logic [7:0] A_RXCNT = 8'h24;
  // control bit positions
  localparam int TC_ON  = 0;
  localparam int TC_PAD = 1;
  localparam int TC_CRC = 2;
  localparam int TC_DPX = 3;
  localparam int RC_ON  = 0;
  localparam int RC_GRP = 1;
  localparam int RC_ALL = 2;
  localparam int RC_BAD = 3;
  localparam int RC_FLS = 4;
  localparam int GRP_WORD_BIT = 16;
  // reset values
  localparam logic [3:0] TXCTL_RST = 4'h6;
  localparam logic [3:0] RXCTL_RST = 4'h8;
  // line constants, counts in nibbles or octets
  localparam logic [3:0]  NIB_PRE   = 4'h5;
  localparam logic [3:0]  NIB_SFD   = 4'hd;
  localparam logic [4:0]  PRE_LAST  = 5'h0f;
  localparam logic [4:0]  FCS_LAST  = 5'h07;
  localparam logic [4:0]  IFG_LAST  = 5'h17;
  localparam int          HDR_BYTES = 32'h0000_000e;
  localparam int          MIN_PAY   = 32'h0000_002e;
  localparam int          HDR_OFS   = 32'h0000_0002;
  localparam logic [15:0] LEN_MAX   = 16'h05dc;
  localparam logic [5:0]  MAX_FRMS  = 6'h1f;
  localparam logic [31:0] CRC_POLY  = 32'hedb8_8320;
  localparam logic [31:0] CRC_INIT  = 32'hffff_ffff;
  localparam logic [31:0] CRC_RES   = 32'hdebb_20e3;
  localparam logic [1:0]  RESP_OK   = 2'b00;
  localparam logic [1:0]  RESP_ERR  = 2'b10;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_PRE = 3'b001, T_BODY = 3'b010,
    T_PAD = 3'b011, T_FCS = 3'b100, T_GAP = 3'b101
  } emf_tx_t;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_PRE = 2'b01, R_DATA = 2'b10, R_SKIP = 2'b11
  } emf_rx_t;

  // reflected crc-32, one nibble, lsb first
  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] n);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++)
      r = (r >> 1) ^ ((r[0] ^ n[i]) ? CRC_POLY : 32'h0000_0000);
    return r;
  endfunction

  // byte-lane merge for strobed writes
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    return r;
  endfunction

  // fifo words taken by a frame of len bytes behind the 2-byte length slot
  function automatic logic [15:0] fw_of(input logic [15:0] len);
    return (len + 16'h0005) >> 2;
  endfunction
endpackage

//--- tb/emf_mac_tb.sv
`timescale 1ns/1ps
module emf_mac_tb;
  import emf_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, tx_clk, tx_en, rx_clk, rx_dv;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, r;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] txd, rxd, f[$];
  logic crs = 0, col = 0;
  logic [7:0] e[64];
  int error_cnt = 0, checks = 0;
  always #2 aclk = ~aclk;
  emf_mac i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mii_tx_clk(tx_clk), .mii_txd(txd), .mii_tx_en(tx_en), .mii_rx_clk(rx_clk),
    .mii_rxd(rxd), .mii_rx_dv(rx_dv), .mii_crs(crs), .mii_col(col));
  emf_phy i_phy (.tx_clk(tx_clk), .txd(txd), .tx_en(tx_en), .rx_clk(rx_clk), .rxd(rxd),
    .rx_dv(rx_dv));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, s, x);
    end
  endtask
  // channels drop valid once taken, ready held until the answer; one idle edge
  // after each call so the next call never reassigns a ready in that step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end
    while (!rvalid);
    r = rdata;
    resp = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  task automatic t_regs;
    rd(A_TXCTL); chk(r[3:0], TXCTL_RST);
    rd(A_RXCTL); chk(r[3:0], RXCTL_RST);
    wr(8'h30, 32'h0000_0001); chk(resp, RESP_ERR);
  endtask
  // one short frame: length 4, addresses, length/type, four data bytes
  task automatic load;
    wr(A_DATA, 32'h1102_0004);
    wr(A_DATA, 32'h5544_3322);
    wr(A_DATA, 32'h0d0c_0b0a);
    wr(A_DATA, 32'h0400_0f0e);
    wr(A_DATA, 32'hd4c3_b2a1);
  endtask
  // short payload: padded to 46, check appended, held until enabled
  task automatic t_tx;
    logic [31:0] c;
    logic [143:0] hb;
    hb = {8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
      8'h00, 8'h04, 8'ha1, 8'hb2, 8'hc3, 8'hd4};
    foreach (e[i])
      e[i] = (i < 18) ? hb[8 * (17 - i) +: 8] : 8'h00;
    c = 32'hffff_ffff;
    for (int i = 0; i < 60; i++)
      for (int b = 0; b < 8; b++)
        c = (c >> 1) ^ ((c[0] ^ e[i][b]) ? 32'hedb8_8320 : 32'h0000_0000);
    for (int k = 0; k < 4; k++)
      e[60 + k] = ~c[8 * k +: 8];
    load;
    wr(A_TXGO, 32'h0000_0001);
    repeat (500) @(posedge aclk);
    chk(i_phy.nq.size(), 0);
    wr(A_TXCTL, 32'h0000_0007);
    wait (i_phy.nq.size() == 144);
    repeat (500) @(posedge aclk);
    chk(i_phy.nq.size(), 144);
    for (int i = 0; i < 15; i++)
      chk(i_phy.nq[i], NIB_PRE);
    chk(i_phy.nq[15], NIB_SFD);
    for (int i = 0; i < 64; i++)
      chk({i_phy.nq[17 + 2 * i], i_phy.nq[16 + 2 * i]}, e[i]);
    rd(A_TXGO); chk(r[0], 1'b0);
    rd(A_EVENT); chk(r[2], 1'b1);
  endtask
  // the sent frame comes back addressed to us, then once corrupted
  task automatic t_rx;
    wr(A_SALO, 32'h3322_1102);
    wr(A_SAHI, 32'h0000_5544);
    wr(A_RXCTL, 32'h0000_0009);
    f = i_phy.nq;
    i_phy.send(f);
    repeat (250) @(posedge aclk);
    rd(A_RXCNT); chk(r[5:0], 6'h01);
    rd(A_DATA); chk(r, 32'h1102_0040);
    rd(A_DATA); chk(r, 32'h5544_3322);
    for (int i = 0; i < 15; i++)
      rd(A_DATA);
    rd(A_RXCNT); chk(r[5:0], 6'h00);
    f[40] = ~f[40];
    i_phy.send(f);
    repeat (250) @(posedge aclk);
    rd(A_RXCNT); chk(r[5:0], 6'h00);
    rd(A_EVENT); chk(r[4], 1'b1);
    // good frame again, first to a foreign station, then promiscuous
    f[40] = ~f[40];
    wr(A_SALO, 32'h0000_0000);
    i_phy.send(f);
    repeat (250) @(posedge aclk);
    rd(A_RXCNT); chk(r[5:0], 6'h00);
    wr(A_RXCTL, 32'h0000_0005);
    i_phy.send(f);
    repeat (250) @(posedge aclk);
    rd(A_RXCNT); chk(r[6:0], 7'h01);
    // flush drops the queued frame; an empty queue reads zero
    wr(A_RXCTL, 32'h0000_0010);
    rd(A_RXCNT); chk(r[5:0], 6'h00);
    rd(A_DATA); chk(r, 32'h0000_0000);
  endtask
  // half duplex: carrier defers the start, a collision aborts the frame
  task automatic t_col;
    crs <= 1;
    wr(A_EVENT, 32'h0000_003f);
    load;
    wr(A_TXGO, 32'h0000_0001);
    repeat (500) @(posedge aclk);
    chk(i_phy.nq.size(), 144);
    crs <= 0;
    col <= 1;
    repeat (500) @(posedge aclk);
    chk(i_phy.nq.size(), 144);
    rd(A_EVENT); chk(r[2:1], 2'b01);
    rd(A_TXGO); chk(r[0], 1'b0);
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs;
    t_tx;
    t_rx;
    t_col;
    summarize;
  end
  // tests need about 36 us
  initial
  begin
    #200000 error_cnt++;
    summarize;
  end
endmodule

//--- tb/emf_phy.sv
`timescale 1ns/1ps
module emf_phy (
  // transmit side
  output logic            tx_clk,
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  // receive side
  output logic            rx_clk,
  output logic [3:0]      rxd,
  output logic            rx_dv
);
  logic [3:0] nq[$];
  initial {tx_clk, rx_clk, rxd, rx_dv} = 7'h00;
  // free running, the mac finds its edges itself
  always #16 tx_clk = ~tx_clk;
  // next rise sees a settled nibble
  always @(posedge tx_clk) if (tx_en) nq.push_back(txd);
  // data moves on the rise, the mac takes it on the fall
  task automatic send(input logic [3:0] f[$]);
    #1; // keep pin changes off the mac clock edges
    foreach (f[i])
    begin
      rxd = f[i];
      rx_dv = 1'b1;
      rx_clk = 1'b1;
      #16 rx_clk = 1'b0;
      #16;
    end
    rxd = ~rxd; // released line shows no stale value
    rx_dv = 1'b0;
    // the mac only sees the frame end on a falling edge with rx_dv low
    repeat (2)
    begin
      rx_clk = 1'b1;
      #16 rx_clk = 1'b0;
      #16;
    end
  endtask
endmodule
